// File: spi2_master.v
// How it works
// R1: control register sits at index 0x10
// R2: software loads command and payload before request
// R3: request starts transfer, hardware clears it after
// R4: busy bit set for whole transfer
// R5: request while busy latches overlap error
// R6: timeout latches flag until software clears
// R7: byte count field is total minus one
// R8: five chip-select enables, any combination
// R9: input enables plus channel pick serial input
// R10: software keeps selected input enable set
// R11: rate field picks 32 kHz to 4.096 MHz
// R12: polarity and phase give four modes
// R13: push-pull default, open-drain drives low only
// R14: shared clock and data out, per-slave selects/inputs
// R15: one 8-bit shift register moves all data; here sh_r shifts out and a second, rx_r, shifts in
// R16: command register 0x11, opcode high, address low
// R17: command out msb first, then payload bytes
// R18: payload at 0x12, lsb aligned bytes
// R19: each select ANDed with its pin level bit
// R20: software sets select pins as driven-high outputs
// R21: write sends 1 to 5 bytes; the 3-bit count field here allows up to 8
// R22: read sends two command bytes, captures rest
// R23: mode 0 data valid at select fall
// R24: selects span all bytes, release before busy clears
// R25: internal counter aborts overlong transfer
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "spi2_consts.vh"

module spi2_master #(
  parameter TIMEOUT_CYCLES = `TIMEOUT_DEFAULT
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // avalon-mm slave
  input  wire [7:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  // general-purpose output levels shared with selects
  input  wire [4:0]  pin_level_bits,
  // serial pins
  output wire        master_sclk_o,
  output wire        master_sclk_oe,
  output wire        mosi_o,
  output wire        mosi_oe,
  output wire [4:0]  cs_o,
  output wire [4:0]  cs_oe,
  input  wire [3:0]  miso_in
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [4:0] S_IDLE  = 5'b0_0001;
  localparam [4:0] S_SETUP = 5'b0_0010;
  localparam [4:0] S_XFER  = 5'b0_0100;
  localparam [4:0] S_HOLD  = 5'b0_1000;
  localparam [4:0] S_END   = 5'b1_0000;
  localparam [31:0] TMO_FULL = TIMEOUT_CYCLES - 1;
  localparam [16:0] TMO_LAST = TMO_FULL[16:0];

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg  [1:0] rst_r;
  wire       rst_sync_n;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_r <= 2'b00;
    end else begin
      rst_r <= {rst_r[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_r[1];

  // ----------------------------------------------------------------
  // registers and engine state
  // ----------------------------------------------------------------
  reg [19:0] cfg_r;
  reg [15:0] cmd_r;
  reg [23:0] pay_r;
  reg        req_r;
  reg        ovl_r;
  reg        tmo_r;
  reg [4:0]  state_r;
  reg [3:0]  edge_r;
  reg [2:0]  idx_r;
  reg [7:0]  sh_r;
  reg [7:0]  rx_r;
  reg        sclk_r;
  reg        mosi_r;
  reg        cs_act_r;
  reg [16:0] tmo_cnt_r;
  reg        ack_r;

  wire [4:0] cs_en = cfg_r[`F_CS_HI:`F_CS_LO];
  wire [3:0] in_en = cfg_r[`F_IEN_HI:`F_IEN_LO];
  wire [1:0] chan  = cfg_r[`F_CH_HI:`F_CH_LO];
  wire [2:0] cnt   = cfg_r[`F_CNT_HI:`F_CNT_LO];
  wire [2:0] rate  = cfg_r[`F_RATE_HI:`F_RATE_LO];
  wire       pol   = cfg_r[`F_POL];
  wire       pha   = cfg_r[`F_PHA];
  wire       odm   = cfg_r[`F_ODM];
  wire       busy  = !state_r[0];
  wire [23:0] ctrl_view = {tmo_r, ovl_r, busy, req_r, cfg_r};

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [23:0] merge;
    input [23:0] old;
    input [31:0] wd;
    input [3:0]  be;
    begin
      merge[7:0]   = be[0] ? wd[7:0]   : old[7:0];
      merge[15:8]  = be[1] ? wd[15:8]  : old[15:8];
      merge[23:16] = be[2] ? wd[23:16] : old[23:16];
    end
  endfunction

  // first two bytes from command, rest from payload top down
  function [7:0] byte_of;
    input [2:0]  i;
    input [2:0]  n;
    input [15:0] c;
    input [23:0] p;
    reg   [2:0]  k;
    begin
      k = n - i;
      if (i == 3'd0) begin
        byte_of = c[15:8]; // [R17]
      end else if (i == 3'd1) begin
        byte_of = c[7:0];
      end else begin
        case (k)
          3'd0:    byte_of = p[7:0]; // [R18]
          3'd1:    byte_of = p[15:8];
          default: byte_of = p[23:16];
        endcase
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // serial input select and clock divider
  // ----------------------------------------------------------------
  wire [3:0] miso_s;
  wire       tick;
  wire       miso = miso_s[chan] & in_en[chan]; // [R9]

  in_sync u_sync (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .pin_in     (miso_in),
    .sync_out   (miso_s)
  );

  sclk_divider u_div (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .run        (busy),
    .rate       (rate), // [R11]
    .tick       (tick)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // one wait cycle: every access completes on the second edge
  wire        acc    = (read | write) & ack_r;
  wire        acc_wr = write & ack_r;
  wire        at_ctl = address[1:0] == 2'b00 &&
                       {2'b00, address[7:2]} == `IDX_CONTROL; // [R1]
  wire        at_cmd = address[1:0] == 2'b00 &&
                       {2'b00, address[7:2]} == `IDX_COMMAND; // [R16]
  wire        at_pay = address[1:0] == 2'b00 &&
                       {2'b00, address[7:2]} == `IDX_PAYLOAD; // [R18]
  wire [23:0] ctl_wr = merge(ctrl_view, writedata, byteenable);
  wire [23:0] cmd_wr = merge({8'h00, cmd_r}, writedata, byteenable);
  wire        req_wr = acc_wr & at_ctl & byteenable[2] & ctl_wr[`F_REQ];
  wire        start  = req_wr & !busy; // [R3]
  wire [7:0]  first  = byte_of(3'd0, ctl_wr[`F_CNT_HI:`F_CNT_LO],
                               cmd_r, pay_r);

  assign waitrequest = (read | write) & !ack_r;

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ack_r    <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      ack_r <= (read | write) & !ack_r;
      if (read & !ack_r) begin
        if (at_ctl)
          readdata <= {8'h00, ctrl_view};
        else if (at_cmd)
          readdata <= {16'h0000, cmd_r};
        else if (at_pay)
          readdata <= {8'h00, pay_r};
        else
          readdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // transfer engine
  // ----------------------------------------------------------------
  wire       lead    = !edge_r[0];
  wire [7:0] rx_byte = pha ? {rx_r[6:0], miso} : rx_r;
  wire       is_rd   = cmd_r[15:8] == `OP_READ;
  wire [2:0] pay_k   = cnt - idx_r;
  wire [7:0] nxt     = byte_of(idx_r + 3'd1, cnt, cmd_r, pay_r);
  wire       tmo_hit = busy && tmo_cnt_r == TMO_LAST;

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cfg_r     <= `CFG_RESET;
      cmd_r     <= `CMD_RESET;
      pay_r     <= `PAY_RESET;
      req_r     <= 1'b0;
      ovl_r     <= 1'b0;
      tmo_r     <= 1'b0;
      state_r   <= S_IDLE;
      edge_r    <= 4'h0;
      idx_r     <= 3'd0;
      sh_r      <= 8'h00;
      rx_r      <= 8'h00;
      sclk_r    <= 1'b0;
      mosi_r    <= 1'b0;
      cs_act_r  <= 1'b0;
      tmo_cnt_r <= 17'h0_0000;
    end else begin
      // flags: clear by writing one; a new event wins
      if (acc_wr & at_ctl & byteenable[2]) begin
        if (ctl_wr[`F_OVL])
          ovl_r <= 1'b0;
        if (ctl_wr[`F_TMO])
          tmo_r <= 1'b0;
      end
      if (req_wr & busy)
        ovl_r <= 1'b1; // [R5]
      // settings and data ignore bus writes while a transfer runs
      if (acc_wr & !busy) begin
        if (at_ctl)
          cfg_r <= ctl_wr[19:0];
        if (at_cmd)
          cmd_r <= cmd_wr[15:0];
        if (at_pay)
          pay_r <= merge(pay_r, writedata, byteenable);
      end
      tmo_cnt_r <= busy ? tmo_cnt_r + 17'h0_0001 : 17'h0_0000;

      if (tmo_hit) begin
        state_r  <= S_IDLE; // [R25]
        cs_act_r <= 1'b0;
        req_r    <= 1'b0;
        tmo_r    <= 1'b1; // [R6]
        sclk_r   <= pol;
      end else begin
        case (state_r)
          S_IDLE: begin
            sclk_r <= acc_wr & at_ctl ? ctl_wr[`F_POL] : pol; // [R12]
            if (start) begin
              state_r  <= S_SETUP; // [R4]
              req_r    <= 1'b1;
              idx_r    <= 3'd0;
              edge_r   <= 4'h0;
              sh_r     <= first; // [R15]
              if (!ctl_wr[`F_PHA])
                mosi_r <= first[7]; // [R23]
            end
          end
          S_SETUP: begin
            // select falls a cycle after the clock took its new polarity
            cs_act_r <= 1'b1; // [R24]
            if (tick)
              state_r <= S_XFER;
          end
          S_XFER: begin
            if (tick) begin
              sclk_r <= !sclk_r;
              edge_r <= edge_r + 4'h1;
              if (lead) begin
                if (!pha) begin
                  rx_r <= {rx_r[6:0], miso}; // [R23]
                end else begin
                  mosi_r <= sh_r[7]; // [R17]
                  sh_r   <= {sh_r[6:0], 1'b0};
                end
              end else begin
                if (pha) begin
                  rx_r <= {rx_r[6:0], miso};
                end else begin
                  mosi_r <= sh_r[6];
                  sh_r   <= {sh_r[6:0], 1'b0};
                end
              end
              if (edge_r == 4'hf) begin
                if (is_rd && idx_r >= 3'd2)
                  pay_r[{pay_k[1:0], 3'b000} +: 8] <= rx_byte; // [R22]
                if (idx_r == cnt) begin
                  state_r <= S_HOLD; // [R7] [R21]
                end else begin
                  idx_r <= idx_r + 3'd1;
                  sh_r  <= nxt;
                  if (!pha)
                    mosi_r <= nxt[7];
                end
              end
            end
          end
          S_HOLD: begin
            if (tick) begin
              state_r  <= S_END;
              cs_act_r <= 1'b0; // [R24]
            end
          end
          S_END: begin
            if (tick) begin
              state_r <= S_IDLE;
              req_r   <= 1'b0; // [R3]
            end
          end
          default: begin
            state_r  <= S_IDLE;
            cs_act_r <= 1'b0;
            req_r    <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // open-drain leans on the pad pull-up; edges slow at high rates
  wire [4:0] cs_val = ~({5{cs_act_r}} & cs_en) & pin_level_bits; // [R8] [R19]

  assign master_sclk_o  = odm ? 1'b0 : sclk_r; // [R13] [R14]
  assign master_sclk_oe = odm ? !sclk_r : 1'b1;
  assign mosi_o         = odm ? 1'b0 : mosi_r;
  assign mosi_oe        = odm ? !mosi_r : 1'b1;
  assign cs_o           = odm ? 5'h00 : cs_val;
  assign cs_oe          = odm ? ~cs_val : 5'h1f;

endmodule // spi2_master

`default_nettype wire

// File: spi2_consts.vh
`ifndef SPI2_CONSTS_VH
`define SPI2_CONSTS_VH

// ----------------------------------------------------------------
// register indices; byte address is four times the index
// ----------------------------------------------------------------
`define IDX_CONTROL      8'h10
`define IDX_COMMAND      8'h11
`define IDX_PAYLOAD      8'h12

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define F_CS_LO          0
`define F_CS_HI          4
`define F_IEN_LO         5
`define F_IEN_HI         8
`define F_CH_LO          9
`define F_CH_HI          10
`define F_CNT_LO         11
`define F_CNT_HI         13
`define F_RATE_LO        14
`define F_RATE_HI        16
`define F_POL            17
`define F_PHA            18
`define F_ODM            19
`define F_REQ            20
`define F_BUSY           21
`define F_OVL            22
`define F_TMO            23
`define CFG_RESET        20'h0_0000
`define CMD_RESET        16'h0000
`define PAY_RESET        24'h00_0000
`define OP_READ          8'h03

// ----------------------------------------------------------------
// timing: serial clock rates and half periods in sys clocks
// ----------------------------------------------------------------
`define CLK_HZ           20000000
`define SCLK_HZ_LO       32000
`define HALF_CYC(k) ((`CLK_HZ + 2*(`SCLK_HZ_LO << (k)) - 1) / (2*(`SCLK_HZ_LO << (k))))
`define TIMEOUT_DEFAULT  65536

`endif

// File: in_sync.v
`timescale 1ns/1ps
`default_nettype none

module in_sync (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst_sync_n,
  // pins and synchronised copy
  input  wire [3:0] pin_in,
  output wire [3:0] sync_out
);

  reg [3:0] meta_r;
  reg [3:0] stable_r;

  // first stage feeds only the second
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      meta_r   <= 4'h0;
      stable_r <= 4'h0;
    end else begin
      meta_r   <= pin_in;
      stable_r <= meta_r;
    end
  end

  assign sync_out = stable_r;

endmodule // in_sync

`default_nettype wire

// File: sclk_divider.v
`timescale 1ns/1ps
`default_nettype none
`include "spi2_consts.vh"

module sclk_divider (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst_sync_n,
  // control
  input  wire       run,
  input  wire [2:0] rate,
  // half period enable pulse
  output reg        tick
);

  reg [8:0] cnt_r;

  // half period rounds up, so the clock never runs above its rate
  function [8:0] half_of;
    input [2:0]  r;
    reg   [31:0] full;
    begin
      case (r)
        3'd0:    full = `HALF_CYC(0);
        3'd1:    full = `HALF_CYC(1);
        3'd2:    full = `HALF_CYC(2);
        3'd3:    full = `HALF_CYC(3);
        3'd4:    full = `HALF_CYC(4);
        3'd5:    full = `HALF_CYC(5);
        3'd6:    full = `HALF_CYC(6);
        default: full = `HALF_CYC(7);
      endcase
      half_of = full[8:0];
    end
  endfunction

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt_r <= 9'h000;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_r <= 9'h000;
      tick  <= 1'b0;
    end else if (cnt_r == half_of(rate) - 9'h001) begin
      cnt_r <= 9'h000;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 9'h001;
      tick  <= 1'b0;
    end
  end

endmodule // sclk_divider

`default_nettype wire

// File: spi2_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ---
// port checker
// ---
module spi2_checker (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // bus
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // pins
  input wire logic [4:0]  pin_level_bits,
  input wire logic        master_sclk_o,
  input wire logic        master_sclk_oe,
  input wire logic        mosi_o,
  input wire logic        mosi_oe,
  input wire logic [4:0]  cs_o,
  input wire logic [4:0]  cs_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // pin levels with the pull-ups of open-drain mode
  wire logic [4:0] cs_l = ~cs_oe | cs_o;
  wire logic       sck_l = !master_sclk_oe | master_sclk_o;
  wire logic       so_l = !mosi_oe | mosi_o;
  sequence s_wait;
    waitrequest ##1 !waitrequest;
  endsequence
  sequence s_quiet;
    ($stable(sck_l) && $stable(so_l)) [*2];
  endsequence
  property p_wait_one;
    $rose(read || write) |-> s_wait;
  endproperty
  property p_wait_idle;
    !(read || write) |-> !waitrequest;
  endproperty
  property p_rd_hold;
    !$past(read) |-> $stable(readdata);
  endproperty
  property p_od_low;
    (!master_sclk_oe || !mosi_oe) |-> !master_sclk_o && !mosi_o && cs_o == 5'h00;
  endproperty
  property p_cs_pin;
    (cs_l & ~pin_level_bits) == 5'h00;
  endproperty
  property p_setup;
    $fell(cs_l[0]) |=> s_quiet;
  endproperty
  property p_first_edge;
    $fell(cs_l[0]) |-> ##[1:700] $changed(sck_l);
  endproperty
  property p_end;
    $rose(cs_l[0]) |=> $stable(sck_l) [*3];
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("wait state count wrong");
  a_wait_idle: assert property (p_wait_idle)
    else $error("wait without request");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without read");
  a_od_low: assert property (p_od_low)
    else $error("open-drain pin driven high");
  a_cs_pin: assert property (p_cs_pin)
    else $error("select high against low pin bit");
  a_setup: assert property (p_setup)
    else $error("lines moved right after select fall");
  a_first_edge: assert property (p_first_edge)
    else $error("no clock edge after select fall");
  a_end: assert property (p_end)
    else $error("clock moved after select release");
endmodule // spi2_checker
bind spi2_master spi2_checker u_spi2_checker (
  .clk_sys(clk_sys), .rst_n(rst_n), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest),
  .pin_level_bits(pin_level_bits), .master_sclk_o(master_sclk_o),
  .master_sclk_oe(master_sclk_oe), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
  .cs_o(cs_o), .cs_oe(cs_oe));
`default_nettype wire

// File: spi_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---
// serial slave on the shared lines
// ---
module spi_slave_model (
  // shared lines
  input  wire logic        sclk,
  input  wire logic        mosi,
  input  wire logic        cs_n,
  input  wire logic        samp_rise,
  // data
  input  wire logic [39:0] tx_word,
  output wire logic        miso,
  output var  logic [39:0] rx_word,
  output var  int          nbits
);
  logic [39:0] tx_r = 0;
  logic        last_r = 0;
  wire logic   sedge = samp_rise ? sclk : !sclk;
  always @(negedge cs_n) begin
    tx_r = tx_word;
    rx_word = 0;
    nbits = 0;
  end
  always @(posedge sedge) if (!cs_n) begin
    rx_word = {rx_word[38:0], mosi};
    nbits++;
  end
  // no shift before the first sample: phase 1 opens with a change edge
  always @(negedge sedge) if (!cs_n && nbits > 0) tx_r = {tx_r[38:0], 1'b0};
  always @(posedge cs_n) last_r = tx_r[39];
  // released line shows the inverse, never a stale bit
  assign miso = cs_n ? !last_r : tx_r[39];
endmodule // spi_slave_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "spi2_consts.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
  localparam logic [7:0] A_CTL = 8'(`IDX_CONTROL * 4);
  localparam logic [7:0] A_CMD = 8'(`IDX_COMMAND * 4);
  localparam logic [7:0] A_PAY = 8'(`IDX_PAYLOAD * 4);
  logic        clk_sys = 0, rst_n = 0, read = 0, write = 0;
  logic [7:0]  address = 0;
  logic [31:0] writedata = 0, readdata, rq;
  logic        waitrequest, sck_o, sck_oe, so_o, so_oe, miso;
  logic [4:0]  pin_level_bits = 5'h1f;
  logic [4:0]  cs_o, cs_oe;
  logic [3:0]  mrnd = 0;
  logic        samp_rise = 1;
  logic [39:0] tx_word = 0, rx_word;
  logic [15:0] lfsr = 16'hc19e, c;
  logic [23:0] v, p, d, m;
  int          nbits, n, fails = 0, checked = 0, cyc = 0;
  wire logic [4:0] cs_l = ~cs_oe | cs_o;
  wire logic       sck_l = !sck_oe | sck_o;
  wire logic       so_l = !so_oe | so_o;
  always #25 clk_sys = ~clk_sys;
  spi2_master #(.TIMEOUT_CYCLES(400)) u_spi2_master (
    .clk_sys(clk_sys), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hf),
    .readdata(readdata), .waitrequest(waitrequest),
    .pin_level_bits(pin_level_bits), .master_sclk_o(sck_o),
    .master_sclk_oe(sck_oe), .mosi_o(so_o), .mosi_oe(so_oe), .cs_o(cs_o),
    .cs_oe(cs_oe), .miso_in({mrnd[3], miso, mrnd[1:0]}));
  spi_slave_model u_spi_slave_model (
    .sclk(sck_l), .mosi(so_l), .cs_n(cs_l[0]), .samp_rise(samp_rise),
    .tx_word(tx_word), .miso(miso), .rx_word(rx_word), .nbits(nbits));
  always @(posedge clk_sys) begin
    mrnd <= lfsr[3:0];
    cyc++;
    if (cyc == 30000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic rnd;
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    v = {lfsr[7:0], lfsr};
  endtask
  // request held until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    address <= a;
    writedata <= wd;
    write <= wr;
    read <= !wr;
    @(posedge clk_sys);
    while (waitrequest !== 1'b0) @(posedge clk_sys);
    rq = readdata;
    write <= 0;
    read <= 0;
    @(posedge clk_sys);
  endtask
  task automatic wait_idle;
    do bus(0, A_CTL, 0); while (rq[`F_BUSY] === 1'b1);
  endtask
  function automatic logic [31:0] ctl(logic [4:0] cs, logic [3:0] ie,
      logic [2:0] cnt, logic [2:0] rt, logic [2:0] md);
    ctl = {12'h001, md, rt, cnt, 2'd2, ie, cs};
  endfunction
  function automatic logic [39:0] stream(logic [15:0] cc, logic [23:0] pp,
      int nb);
    stream = 0;
    for (int i = 0; i < nb; i++)
      stream = {stream[31:0], (i == 0) ? cc[15:8] : (i == 1) ? cc[7:0] :
                8'(pp >> (8 * (nb - 1 - i)))};
  endfunction
  task tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1;
    repeat (3) @(posedge clk_sys);
    bus(1, 8'h4c, 32'hffff_ffff);
    for (int i = 0; i < 4; i++) begin
      bus(0, (i == 3) ? 8'h4c : A_CTL + 8'(4 * i), 0);
      `CHK("reset value", 32'h0, rq)
    end
    rnd();
    bus(1, A_CMD, {v, 8'hff});
    bus(0, A_CMD, 0);
    `CHK("command", {16'h0, v[7:0], 8'hff}, rq)
    bus(1, A_PAY, {8'hff, v});
    bus(0, A_PAY, 0);
    `CHK("payload", {8'h0, v}, rq)
    for (int k = 0; k < 5; k++) begin
      rnd();
      c = {8'h02, v[7:0]};
      rnd();
      p = v;
      bus(1, A_CMD, c);
      bus(1, A_PAY, p);
      samp_rise <= (k[0] == k[1]);
      pin_level_bits <= (k == 2) ? 5'h1d : 5'h1f;
      bus(1, A_CTL, ctl(5'h03, 4'h4, k[2:0], 3'd7, {k == 3, k[1:0]}));
      bus(0, A_CTL, 0);
      `CHK("busy", 2'b11, rq[`F_BUSY:`F_REQ])
      if (k == 4) begin
        bus(1, A_CTL, ctl(5'h01, 4'h4, 3'd0, 3'd7, 3'd0));
        bus(0, A_CTL, 0);
        `CHK("overlap", 1'b1, rq[`F_OVL])
      end
      wait_idle();
      `CHK("done", {k == 4, 2'b00}, rq[`F_OVL:`F_REQ])
      `CHK("sent", stream(c, p, k + 1), rx_word)
      `CHK("bits", 8 * (k + 1), nbits)
      `CHK("idle clock", k[0], sck_l)
      `CHK("masked select", (k == 2) ? 1'b0 : 1'b1, cs_l[1])
    end
    bus(1, A_CTL, 32'h0040_0000);
    bus(0, A_CTL, 0);
    `CHK("overlap clear", 1'b0, rq[`F_OVL])
    for (int k = 0; k < 3; k++) begin
      rnd();
      d = v;
      rnd();
      p = v;
      c = {`OP_READ, v[7:0]};
      n = (k == 1) ? 5 : 3;
      samp_rise <= (k != 2);
      tx_word <= {16'h0000, d << (8 * (5 - n))};
      bus(1, A_CMD, c);
      bus(1, A_PAY, p);
      bus(1, A_CTL, ctl(5'h01, (k == 2) ? 4'h0 : 4'h4, 3'(n - 1), 3'd7,
                        {1'b0, k != 0, k[0]}));
      wait_idle();
      bus(0, A_PAY, 0);
      m = (24'h1 << (8 * (n - 2))) - 24'h1;
      `CHK("read", {8'h0, (p & ~m) | ((k == 2) ? 24'h0 : d & m)}, rq)
    end
    bus(1, A_CTL, ctl(5'h02, 4'h4, 3'd4, 3'd0, 3'd0));
    wait_idle();
    `CHK("timeout", 4'b1000, rq[`F_TMO:`F_REQ])
    bus(1, A_CTL, 32'h0080_0000);
    bus(0, A_CTL, 0);
    `CHK("timeout clear", 1'b0, rq[`F_TMO])
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
